// [shared/sst_cfg.svh]
`ifndef SST_CFG_SVH
`define SST_CFG_SVH

// Register offsets on the plain register port
`define SST_A_IRQCTL 4'h0
`define SST_A_PIRQEN 4'h1
`define SST_A_PIRQFL 4'h2
`define SST_A_RXSTC 4'h3
`define SST_A_BAUD 4'h4
`define SST_A_HOLD 4'h5
`define SST_A_TXSTC 4'h6
`define SST_A_EVST 4'h7
`define SST_A_EVCLR 4'h8
`define SST_A_EVEN 4'h9
`define SST_A_LINK 4'hA

// Field positions
`define SST_IC_GLOBAL 7
`define SST_IC_PERIPH 6
`define SST_PI_TXFREE 4
`define SST_RS_SERIAL_PORT_ENABLE 7
`define SST_RS_SINGLE_RECEIVE_ENABLE 5
`define SST_RS_CONTINUOUS_RECEIVE_ENABLE 4
`define SST_RS_ADDRESS_DETECT_ENABLE 3
`define SST_TS_CLOCK_SOURCE_SELECT 7
`define SST_TS_NINE 6
`define SST_TS_TRANSMIT_ENABLE 5
`define SST_TS_SYNC 4
`define SST_TS_EMPTY 1
`define SST_TS_NINTH 0
`define SST_EV_LOAD 0
`define SST_EV_DONE 1
`define SST_LK_CK 0
`define SST_LK_DT 1

// Write masks: status and unimplemented bits are not stored
`define SST_TS_WMASK 8'hF5
`define SST_RS_WMASK 8'hF8

// Reset values and frame lengths
`define SST_RST8 8'h00
`define SST_RST_EV 2'h0
`define SST_LEN8 4'h8
`define SST_LEN9 4'h9
`define SST_CNT_ZERO 4'h0
`define SST_CNT_STEP 4'h1
`define SST_NEV 2

`endif

// [shared/sst_pkg.sv]
package sst_pkg;
    typedef logic [3:0] sst_addr_type;
    typedef logic [7:0] sst_byte_type;
    typedef logic [8:0] sst_word_type;
    typedef logic [1:0] sst_ev_type;
    typedef enum logic {SST_IDLE, SST_SHIFT} sst_state_type;
endpackage

// [shared/sst_shift_if.sv]
`timescale 1ns/1ns
interface sst_shift_if;
    logic load;
    sst_pkg::sst_word_type word;
    logic len9;
    logic abort;
    logic ck_rise;
    logic ck_fall;
    logic empty;
    logic done;
    logic dt_out;
    modport ctrl(output load, word, len9, abort, ck_rise, ck_fall,
                 input empty, done, dt_out);
    modport shift(input load, word, len9, abort, ck_rise, ck_fall,
                  output empty, done, dt_out);
endinterface

// [hdl/sst_shifter.sv]
`timescale 1ns/1ns
`include "sst_cfg.svh"
module sst_shifter (
    input wire logic mclk,
    input wire logic rst_n,
    sst_shift_if.shift sif
);
    import sst_pkg::*;

    sst_state_type st_reg, st_next;
    sst_word_type sr_reg, sr_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [3:0] len_reg, len_next;
    logic dt_reg, dt_next;
    logic done_reg, done_next;

    // Next-state of the transmit shift register, LSB first
    always_comb begin
        st_next = st_reg;
        sr_next = sr_reg;
        cnt_next = cnt_reg;
        len_next = len_reg;
        dt_next = dt_reg;
        done_next = 1'b0;
        if (sif.abort) begin
            st_next = SST_IDLE;
            cnt_next = `SST_CNT_ZERO;
        end else begin
            case (st_reg)
                SST_IDLE: begin
                    if (sif.load) begin
                        st_next = SST_SHIFT;
                        sr_next = sif.word;
                        len_next = sif.len9 ? `SST_LEN9 : `SST_LEN8;
                        cnt_next = `SST_CNT_ZERO;
                    end
                end
                SST_SHIFT: begin
                    // Master clock rise puts next bit out; fall after last ends
                    if (sif.ck_rise && cnt_reg != len_reg) begin
                        dt_next = sr_reg[0];
                        sr_next = {1'b0, sr_reg[8:1]};
                        cnt_next = cnt_reg + `SST_CNT_STEP;
                    end else if (sif.ck_fall && cnt_reg == len_reg) begin
                        st_next = SST_IDLE;
                        done_next = 1'b1;
                    end
                end
                default: begin
                    st_next = SST_IDLE;
                end
            endcase
        end
    end

    // Register stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg <= SST_IDLE;
            sr_reg <= '0;
            cnt_reg <= `SST_CNT_ZERO;
            len_reg <= `SST_LEN8;
            dt_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            sr_reg <= sr_next;
            cnt_reg <= cnt_next;
            len_reg <= len_next;
            dt_reg <= dt_next;
            done_reg <= done_next;
        end
    end

    assign sif.empty = (st_reg == SST_IDLE);
    assign sif.done = done_reg;
    assign sif.dt_out = dt_reg;
endmodule

// [hdl/sst_top.sv]
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "sst_cfg.svh"
// Overview of operation
// - Sync mode, slave clock, port enable bits
// - Transmit only while both receive enables clear
// - Behaves like master transmit except sleep
// - In sleep, first loads, second waits
// - After first shifts out, second loads, flag
// - Flag with enables wakes; global enables service
// - Nine-bit option sends dedicated ninth bit
// - Transmit enable; writing holding starts transfer
module sst_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sst_pkg::sst_addr_type bus_addr,
    input wire sst_pkg::sst_byte_type bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output sst_pkg::sst_byte_type bus_rdata,
    input wire logic link_ck,
    input wire logic link_dt_in,
    output logic link_dt_out,
    output logic link_dt_oe,
    input wire logic sleep_mode,
    output logic wake_req,
    output logic isr_req,
    output logic irq
);
    import sst_pkg::*;

    sst_shift_if sif();

    // Software-visible storage
    sst_byte_type ictl_reg, ictl_next;
    sst_byte_type pie_reg, pie_next;
    sst_byte_type rsc_reg, rsc_next;
    sst_byte_type baud_reg, baud_next;
    sst_byte_type tsc_reg, tsc_next;
    sst_byte_type hold_reg, hold_next;
    logic hold9_reg, hold9_next;
    logic full_reg, full_next;
    sst_ev_type evst_reg, evst_next;
    sst_ev_type even_reg, even_next;
    sst_byte_type rdata_reg, rdata_next;

    // Pin synchronisers and edge history
    logic ck_s1_reg, ck_s2_reg, ck_s3_reg;
    logic ck_s1_next, ck_s2_next, ck_s3_next;
    logic dt_s1_reg, dt_s2_reg;
    logic dt_s1_next, dt_s2_next;

    // Registered interrupt and wake outputs
    logic irq_reg, irq_next;
    logic wake_reg, wake_next;
    logic isr_reg, isr_next;

    // Decoded control and events
    logic tx_active;
    logic buf_free;
    logic load;
    logic wr_hold;
    logic wr_clr;
    sst_ev_type ev;
    sst_byte_type tsc_view;
    sst_byte_type pir_view;
    sst_byte_type link_view;

    // Transmit path is live only in synchronous slave transmit setup
    assign tx_active = rsc_reg[`SST_RS_SERIAL_PORT_ENABLE]
                     & tsc_reg[`SST_TS_SYNC]
                     & ~tsc_reg[`SST_TS_CLOCK_SOURCE_SELECT]
                     & ~rsc_reg[`SST_RS_SINGLE_RECEIVE_ENABLE]
                     & ~rsc_reg[`SST_RS_CONTINUOUS_RECEIVE_ENABLE]
                     & tsc_reg[`SST_TS_TRANSMIT_ENABLE];

    // Address detect is left to software and does not gate sending

    // Holding moves into an idle shifter, in sleep or not alike
    assign load = tx_active & full_reg & sif.empty;

    // Buffer-free flag: holding register can take another character
    assign buf_free = tx_active & ~full_reg;

    assign wr_hold = bus_wr & (bus_addr == `SST_A_HOLD);
    assign wr_clr = bus_wr & (bus_addr == `SST_A_EVCLR);

    // Events that set sticky status bits
    always_comb begin
        ev = `SST_RST_EV;
        ev[`SST_EV_LOAD] = load;
        ev[`SST_EV_DONE] = sif.done;
    end

    // Read views with hardware status bits merged in
    always_comb begin
        tsc_view = tsc_reg;
        tsc_view[`SST_TS_EMPTY] = sif.empty;
        pir_view = `SST_RST8;
        pir_view[`SST_PI_TXFREE] = buf_free;
        link_view = `SST_RST8;
        link_view[`SST_LK_CK] = ck_s2_reg;
        link_view[`SST_LK_DT] = dt_s2_reg;
    end

    // Drive the shifter through the shared interface
    assign sif.load = load;
    assign sif.word = {hold9_reg, hold_reg};
    assign sif.len9 = tsc_reg[`SST_TS_NINE];
    assign sif.abort = ~tx_active;
    assign sif.ck_rise = ck_s2_reg & ~ck_s3_reg;
    assign sif.ck_fall = ~ck_s2_reg & ck_s3_reg;

    sst_shifter u_shift (
        .mclk(mclk),
        .rst_n(rst_n),
        .sif(sif)
    );

    // Next values of configuration registers
    always_comb begin
        ictl_next = ictl_reg;
        pie_next = pie_reg;
        rsc_next = rsc_reg;
        baud_next = baud_reg;
        tsc_next = tsc_reg;
        even_next = even_reg;
        if (bus_wr) begin
            case (bus_addr)
                `SST_A_IRQCTL: ictl_next = bus_wdata;
                `SST_A_PIRQEN: pie_next = bus_wdata;
                `SST_A_RXSTC: rsc_next = bus_wdata & `SST_RS_WMASK;
                `SST_A_BAUD: baud_next = bus_wdata;
                `SST_A_TXSTC: tsc_next = bus_wdata & `SST_TS_WMASK;
                `SST_A_EVEN: even_next = bus_wdata[`SST_NEV-1:0];
                default: ictl_next = ictl_reg;
            endcase
        end
    end

    // Configuration register stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ictl_reg <= `SST_RST8;
            pie_reg <= `SST_RST8;
            rsc_reg <= `SST_RST8;
            baud_reg <= `SST_RST8;
            tsc_reg <= `SST_RST8;
            even_reg <= `SST_RST_EV;
        end else begin
            ictl_reg <= ictl_next;
            pie_reg <= pie_next;
            rsc_reg <= rsc_next;
            baud_reg <= baud_next;
            tsc_reg <= tsc_next;
            even_reg <= even_next;
        end
    end

    // Holding register: a new write wins over the transfer out
    always_comb begin
        hold_next = hold_reg;
        hold9_next = hold9_reg;
        full_next = full_reg;
        if (load) begin
            full_next = 1'b0;
        end
        if (wr_hold) begin
            hold_next = bus_wdata;
            hold9_next = tsc_reg[`SST_TS_NINTH];
            full_next = 1'b1;
        end
    end

    // Holding register stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold_reg <= `SST_RST8;
            hold9_reg <= 1'b0;
            full_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            hold9_reg <= hold9_next;
            full_reg <= full_next;
        end
    end

    // Sticky event bits; a set in the clear cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < `SST_NEV; gi = gi + 1) begin : g_ev
            assign evst_next[gi] = ev[gi] | (evst_reg[gi] & ~(wr_clr & bus_wdata[gi]));
        end
    endgenerate

    // Event status stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            evst_reg <= `SST_RST_EV;
        end else begin
            evst_reg <= evst_next;
        end
    end

    // Pin synchronisers: the second stage feeds logic, and the clock's third stage feeds the edge detect
    always_comb begin
        ck_s1_next = link_ck;
        ck_s2_next = ck_s1_reg;
        ck_s3_next = ck_s2_reg;
        dt_s1_next = link_dt_in;
        dt_s2_next = dt_s1_reg;
    end

    // Synchroniser stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
            ck_s3_reg <= 1'b0;
            dt_s1_reg <= 1'b0;
            dt_s2_reg <= 1'b0;
        end else begin
            ck_s1_reg <= ck_s1_next;
            ck_s2_reg <= ck_s2_next;
            ck_s3_reg <= ck_s3_next;
            dt_s1_reg <= dt_s1_next;
            dt_s2_reg <= dt_s2_next;
        end
    end

    // Wake and service requests from the buffer-free flag; irq from enabled event status bits
    always_comb begin
        wake_next = buf_free & pie_reg[`SST_PI_TXFREE]
                  & ictl_reg[`SST_IC_PERIPH];
        isr_next = wake_next & ictl_reg[`SST_IC_GLOBAL];
        irq_next = |(evst_reg & even_reg);
    end

    // Request output stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wake_reg <= 1'b0;
            isr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            wake_reg <= wake_next;
            isr_reg <= isr_next;
            irq_reg <= irq_next;
        end
    end

    // Read data for the cycle after a read strobe, zero otherwise
    always_comb begin
        rdata_next = `SST_RST8;
        if (bus_rd) begin
            case (bus_addr)
                `SST_A_IRQCTL: rdata_next = ictl_reg;
                `SST_A_PIRQEN: rdata_next = pie_reg;
                `SST_A_PIRQFL: rdata_next = pir_view;
                `SST_A_RXSTC: rdata_next = rsc_reg;
                `SST_A_BAUD: rdata_next = baud_reg;
                `SST_A_TXSTC: rdata_next = tsc_view;
                `SST_A_EVST: rdata_next = {6'h00, evst_reg};
                `SST_A_EVEN: rdata_next = {6'h00, even_reg};
                `SST_A_LINK: rdata_next = link_view;
                default: rdata_next = `SST_RST8;
            endcase
        end
    end

    // Read data stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_reg <= `SST_RST8;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Outputs; data pin is driven only while transmitting is set up
    assign bus_rdata = rdata_reg;
    assign link_dt_out = sif.dt_out;
    assign link_dt_oe = tx_active;
    assign wake_req = wake_reg;
    assign isr_req = isr_reg;
    assign irq = irq_reg;
endmodule

// [tb/sst_master_model.sv]
`timescale 1ns/1ns
module sst_master_model (
    input wire logic go,
    input wire logic [3:0] nbits,
    input wire logic dt,
    output logic link_ck,
    output sst_pkg::sst_word_type word
);
    import sst_pkg::*;
    // Clock stands low between frames; bits are taken late in the low phase
    initial begin
        link_ck = 1'b0;
        word = 9'h000;
        forever begin
            @(posedge go);
            #37;
            word = 9'h000;
            for (int i = 0; i < nbits; i++) begin
                link_ck = 1'b1;
                #400;
                link_ck = 1'b0;
                #300;
                word[i] = dt;
                #100;
            end
        end
    end
endmodule

// [tb/sst_chk.sv]
`timescale 1ns/1ns
`include "sst_cfg.svh"
module sst_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sst_pkg::sst_addr_type bus_addr,
    input wire sst_pkg::sst_byte_type bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire sst_pkg::sst_byte_type bus_rdata,
    input wire logic link_ck,
    input wire logic link_dt_out,
    input wire logic link_dt_oe,
    input wire logic wake_req,
    input wire logic isr_req,
    input wire logic irq
);
    import sst_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_hold_wo; bus_rd && bus_addr == `SST_A_HOLD |=> bus_rdata == 8'h00; endproperty
    a_hold_wo: assert property (p_hold_wo) else $error("holding read not zero");
    property p_oe_rx; bus_wr && bus_addr == `SST_A_RXSTC && bus_wdata[5] |=> !link_dt_oe; endproperty
    a_oe_rx: assert property (p_oe_rx) else $error("drives while receiving");
    property p_oe_serial_port_enable; bus_wr && bus_addr == `SST_A_RXSTC && !bus_wdata[7] |=> !link_dt_oe; endproperty
    a_oe_serial_port_enable: assert property (p_oe_serial_port_enable) else $error("drives while port off");
    property p_oe_sync; bus_wr && bus_addr == `SST_A_TXSTC && !bus_wdata[4] |=> !link_dt_oe; endproperty
    a_oe_sync: assert property (p_oe_sync) else $error("drives while not sync");
    property p_dt_ck;
        $changed(link_dt_out) |-> $past(link_ck, 2) || $past(link_ck, 3) || $past(link_ck, 4);
    endproperty
    a_dt_ck: assert property (p_dt_ck) else $error("data moved without clock");
    property p_isr_wake; isr_req |-> wake_req; endproperty
    a_isr_wake: assert property (p_isr_wake) else $error("service without wake");
    property p_wake_en; bus_wr && bus_addr == `SST_A_PIRQEN && !bus_wdata[4] |-> ##2 !wake_req; endproperty
    a_wake_en: assert property (p_wake_en) else $error("wake while disabled");
    property p_isr_gie; bus_wr && bus_addr == `SST_A_IRQCTL && !bus_wdata[7] |-> ##2 !isr_req; endproperty
    a_isr_gie: assert property (p_isr_gie) else $error("service while global off");
    property p_irq_mask; bus_wr && bus_addr == `SST_A_EVEN && bus_wdata == 8'h00 |-> ##2 !irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    c_irq: cover property ($rose(irq));
    c_isr: cover property ($rose(isr_req));
    c_oe: cover property ($rose(link_dt_oe));
endmodule

// [tb/sst_top_tb.sv]
`timescale 1ns/1ns
`include "sst_cfg.svh"
module sst_top_tb;
    import sst_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    sst_addr_type bus_addr = 4'h0;
    sst_byte_type bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic sleep_mode = 1'b0;
    logic go = 1'b0;
    logic [3:0] nbits = 4'h8;
    sst_byte_type bus_rdata;
    logic link_ck, link_dt_out, link_dt_oe, wake_req, isr_req, irq;
    sst_word_type rx_word;
    sst_word_type exp_q[$];
    sst_byte_type b;
    logic [31:0] seed = 32'h0000BC00;
    int fails = 0;
    int cmp_count = 0;
    // Released pin shows the inverse of the last driven level
    wire logic dt_pin = link_dt_oe ? link_dt_out : ~link_dt_out;

    always #50 mclk = ~mclk;

    sst_top uut (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .link_ck(link_ck),
        .link_dt_in(dt_pin), .link_dt_out(link_dt_out), .link_dt_oe(link_dt_oe),
        .sleep_mode(sleep_mode), .wake_req(wake_req), .isr_req(isr_req), .irq(irq));
    sst_master_model u_master (.go(go), .nbits(nbits), .dt(dt_pin), .link_ck(link_ck),
        .word(rx_word));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction

    task automatic chk(input string n, input sst_word_type e, input sst_word_type s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input sst_addr_type a, input sst_byte_type d);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
        // Let the write settle before any level output is looked at
        #10;
    endtask

    task automatic rd(input sst_addr_type a, input sst_byte_type e);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #10;
        chk($sformatf("reg%0h", a), {1'b0, e}, {1'b0, bus_rdata});
    endtask

    // Writes a character and records what the master should receive
    task automatic send(input sst_byte_type d, input logic ninth);
        wr(`SST_A_HOLD, d);
        exp_q.push_back({ninth, d});
    endtask

    task automatic frame(input logic [3:0] n);
        sst_word_type e;
        e = exp_q.pop_front();
        @(posedge mclk);
        nbits <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (n * 8 + 8) @(posedge mclk);
        chk("frame", e, rx_word);
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        #2000000;
        fails++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`SST_A_TXSTC, 8'h02);
        rd(`SST_A_PIRQEN, 8'h00);
        rd(`SST_A_PIRQFL, 8'h00);
        rd(`SST_A_BAUD, 8'h00);
        rd(`SST_A_HOLD, 8'h00);
        rd(4'hF, 8'h00);
        rd(`SST_A_LINK, 8'h02);
        $display("reset test done");
        wr(`SST_A_RXSTC, 8'h20);
        wr(`SST_A_TXSTC, 8'h30);
        chk("oe", 9'h000, link_dt_oe);
        wr(`SST_A_RXSTC, 8'hA0);
        chk("oe", 9'h000, link_dt_oe);
        wr(`SST_A_RXSTC, 8'h90);
        chk("oe", 9'h000, link_dt_oe);
        rd(`SST_A_PIRQFL, 8'h00);
        wr(`SST_A_TXSTC, 8'h10);
        wr(`SST_A_RXSTC, 8'h80);
        wr(`SST_A_IRQCTL, 8'h40);
        wr(`SST_A_PIRQEN, 8'h10);
        wr(`SST_A_EVEN, 8'h02);
        wr(`SST_A_TXSTC, 8'h30);
        rd(`SST_A_PIRQFL, 8'h10);
        rd(`SST_A_TXSTC, 8'h32);
        chk("oe", 9'h001, link_dt_oe);
        $display("setup test done");
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            b = seed[7:0];
            send(b, 1'b0);
            repeat (3) @(posedge mclk);
            rd(`SST_A_PIRQFL, 8'h10);
            frame(4'h8);
            chk("irq", 9'h001, irq);
            wr(`SST_A_EVCLR, 8'h02);
            repeat (3) @(posedge mclk);
            chk("irq", 9'h000, irq);
            rd(`SST_A_EVST, 8'h01);
        end
        $display("byte test done");
        wr(`SST_A_TXSTC, 8'h71);
        seed = xs(seed);
        send(seed[7:0], 1'b1);
        repeat (3) @(posedge mclk);
        frame(4'h9);
        wr(`SST_A_TXSTC, 8'h30);
        $display("nine bit test done");
        sleep_mode <= 1'b1;
        send(8'hC3, 1'b0);
        repeat (4) @(posedge mclk);
        send(8'h3C, 1'b0);
        repeat (3) @(posedge mclk);
        rd(`SST_A_PIRQFL, 8'h00);
        chk("wake", 9'h000, wake_req);
        frame(4'h8);
        rd(`SST_A_PIRQFL, 8'h10);
        chk("wake", 9'h001, wake_req);
        chk("isr", 9'h000, isr_req);
        wr(`SST_A_IRQCTL, 8'hC0);
        repeat (3) @(posedge mclk);
        chk("isr", 9'h001, isr_req);
        frame(4'h8);
        $display("sleep test done");
        wr(`SST_A_EVEN, 8'h00);
        wr(`SST_A_PIRQEN, 8'h00);
        wr(`SST_A_IRQCTL, 8'h00);
        repeat (3) @(posedge mclk);
        chk("irq", 9'h000, irq);
        chk("wake", 9'h000, wake_req);
        wr(`SST_A_TXSTC, 8'h00);
        chk("oe", 9'h000, link_dt_oe);
        $display("mask test done");
        end_of_test();
    end
endmodule

bind sst_top sst_chk u_chk (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .link_ck(link_ck), .link_dt_out(link_dt_out), .link_dt_oe(link_dt_oe),
    .wake_req(wake_req), .isr_req(isr_req), .irq(irq));
